//--- design/rdsw_params.svh
`ifndef RDSW_PARAMS_SVH
`define RDSW_PARAMS_SVH

// register byte addresses
`define RDSW_ADDR_CTRL     8'h00
`define RDSW_ADDR_MAX_ON   8'h04
`define RDSW_ADDR_MAX_OFF  8'h08
`define RDSW_ADDR_TIMEBASE 8'h0C
`define RDSW_ADDR_STATUS   8'h10
`define RDSW_ADDR_ELAPSED  8'h14
`define RDSW_ADDR_TARGET   8'h18

// control fields
`define RDSW_CTRL_RETAIN   0
`define RDSW_CTRL_ON_EXT   1
`define RDSW_CTRL_OFF_EXT  2

// reset values
`define RDSW_MAX_ON_RST    16'h000A
`define RDSW_MAX_OFF_RST   16'h000A
`define RDSW_LFSR_SEED     24'h5A5A5A

// time base: one tick of elapsed time
`define RDSW_CLK_PERIOD_NS 10
`define RDSW_TICK_NS       10000000
`define RDSW_TICK_CYCLES   (`RDSW_TICK_NS / `RDSW_CLK_PERIOD_NS)

// axi responses
`define RDSW_RESP_OKAY     2'h0
`define RDSW_RESP_SLVERR   2'h2

`endif

//--- design/rdsw_pkg.sv
`default_nettype none
`include "rdsw_params.svh"

package rdsw_pkg;

  typedef enum logic [1:0] {
    RDSW_IDLE     = 2'b00,
    RDSW_ON_WAIT  = 2'b01,
    RDSW_OFF_WAIT = 2'b10
  } rdsw_mode_t;

  typedef struct packed {
    logic        gate_s1;
    logic        gate_s2;
    logic        gate_d;
    logic        pwr_s1;
    logic        pwr_s2;
    logic        pwr_d;
    rdsw_mode_t  mode;
    logic        sw;
    logic [15:0] elapsed;
    logic [15:0] target;
    logic [23:0] pre_cnt;
    rdsw_mode_t  sv_mode;
    logic        sv_sw;
    logic [15:0] sv_elapsed;
    logic [15:0] sv_target;
    logic [2:0]  ctrl;
    logic [15:0] max_on;
    logic [15:0] max_off;
    logic [23:0] prescale;
    logic        aw_got;
    logic [7:0]  aw_addr;
    logic        w_got;
    logic [31:0] wdata;
    logic [3:0]  wstrb;
    logic        awready;
    logic        wready;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        arready;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
  } rdsw_state_t;

endpackage : rdsw_pkg
`default_nettype wire

//--- design/rdsw_lfsr.sv
`timescale 1ns/10ps
`default_nettype none
`include "rdsw_params.svh"

module rdsw_lfsr #(
  parameter int WIDTH = 24
) (
  input  wire logic        i_sys_clk,
  input  wire logic        i_reset_n,
  output var  logic [15:0] o_value
);

  logic [23:0] lfsr;

  if (WIDTH != 24)
  begin : g_width_check
    $error("rdsw_lfsr: taps are fixed for WIDTH 24");
  end

  // free running, never stalls, so the draw depends on when the edge arrives
  always_ff @(posedge i_sys_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
      lfsr <= `RDSW_LFSR_SEED;
    else
      lfsr <= {lfsr[22:0], lfsr[23] ^ lfsr[22] ^ lfsr[21] ^ lfsr[16]};
  end

  // upper bits of a nonzero state still span 0000 to FFFF
  assign o_value = lfsr[23:8];

endmodule : rdsw_lfsr
`default_nettype wire

//--- design/rdsw_top.sv
// Notes on behaviour
// - gate rising edge starts an on-delay drawn at random from zero to max_on_delay
// - output sets when on-delay elapses, only if gate stayed high throughout
// - gate falling during on-delay clears elapsed time; output is not set
// - gate falling edge starts an off-delay drawn at random from zero to max_off_delay
// - output clears when off-delay elapses, only if gate stayed low throughout
// - gate rising during off-delay clears elapsed time; output stays unchanged
// - retention restores output and elapsed time after power return, else defaults
// - either maximum may come from another block's live value instead of its writable register
`timescale 1ns/10ps
`default_nettype none
`include "rdsw_params.svh"

module rdsw_top
  import rdsw_pkg::*;
#(
  parameter int TICK_CYCLES = `RDSW_TICK_CYCLES
) (
  input  wire logic        i_sys_clk,
  input  wire logic        i_reset_n,
  input  wire logic        i_gate,
  input  wire logic        i_power_ok,
  input  wire logic [15:0] i_ext_max_on,
  input  wire logic [15:0] i_ext_max_off,
  output var  logic        o_switch,
  output var  logic [15:0] o_elapsed_time,
  input  wire logic [7:0]  i_awaddr,
  input  wire logic        i_awvalid,
  output var  logic        o_awready,
  input  wire logic [31:0] i_wdata,
  input  wire logic [3:0]  i_wstrb,
  input  wire logic        i_wvalid,
  output var  logic        o_wready,
  output var  logic [1:0]  o_bresp,
  output var  logic        o_bvalid,
  input  wire logic        i_bready,
  input  wire logic [7:0]  i_araddr,
  input  wire logic        i_arvalid,
  output var  logic        o_arready,
  output var  logic [31:0] o_rdata,
  output var  logic [1:0]  o_rresp,
  output var  logic        o_rvalid,
  input  wire logic        i_rready
);

  rdsw_state_t r;
  rdsw_state_t next_r;
  logic [15:0] rand_value;

  if (TICK_CYCLES < 1 || TICK_CYCLES > 24'hFFFFFF)
  begin : g_tick_check
    $error("rdsw_top: TICK_CYCLES must fit 1 to 2**24-1");
  end

  rdsw_lfsr #(
    .WIDTH (24)
  ) rdsw_lfsr_i (
    .i_sys_clk (i_sys_clk),
    .i_reset_n (i_reset_n),
    .o_value   (rand_value)
  );

  function automatic logic addr_ok(input logic [7:0] a);
    addr_ok = (a == `RDSW_ADDR_CTRL) || (a == `RDSW_ADDR_MAX_ON) || (a == `RDSW_ADDR_MAX_OFF)
           || (a == `RDSW_ADDR_TIMEBASE) || (a == `RDSW_ADDR_STATUS)
           || (a == `RDSW_ADDR_ELAPSED) || (a == `RDSW_ADDR_TARGET);
  endfunction : addr_ok

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d, input logic [3:0] s);
    logic [31:0] m;
    m = old;
    for (int b = 0; b < 4; b++)
    begin
      if (s[b])
        m[b*8 +: 8] = d[b*8 +: 8];
    end
    merge = m;
  endfunction : merge

  // product of draw and (max + 1), top half gives 0..max inclusive
  function automatic logic [15:0] scale(input logic [15:0] rv, input logic [15:0] mx);
    logic [32:0] p;
    p = {17'h00000, rv} * {16'h0000, ({1'b0, mx} + 17'h00001)};
    scale = p[31:16];
  endfunction : scale

  logic        pwr_fall;
  logic        pwr_rise;
  logic        gate_rise;
  logic        gate_fall;
  logic        tick;
  logic [15:0] lim_on;
  logic [15:0] lim_off;
  logic [23:0] pre_top;
  logic [31:0] wmerged;

  always_comb
  begin
    next_r    = r;
    pwr_fall  = r.pwr_d & ~r.pwr_s2;
    pwr_rise  = ~r.pwr_d & r.pwr_s2;
    gate_rise = r.pwr_s2 & r.pwr_d & r.gate_s2 & ~r.gate_d;
    gate_fall = r.pwr_s2 & r.pwr_d & ~r.gate_s2 & r.gate_d;
    lim_on    = r.ctrl[`RDSW_CTRL_ON_EXT] ? i_ext_max_on : r.max_on;
    lim_off   = r.ctrl[`RDSW_CTRL_OFF_EXT] ? i_ext_max_off : r.max_off;
    pre_top   = (r.prescale == 24'h000000) ? 24'h000000 : r.prescale - 24'h000001;
    tick      = (r.pre_cnt >= pre_top);
    wmerged   = 32'h00000000;

    next_r.gate_s1 = i_gate;
    next_r.gate_s2 = r.gate_s1;
    next_r.gate_d  = r.gate_s2;
    next_r.pwr_s1  = i_power_ok;
    next_r.pwr_s2  = r.pwr_s1;
    next_r.pwr_d   = r.pwr_s2;

    // time base runs only while powered
    if (!r.pwr_s2 || tick)
      next_r.pre_cnt = 24'h000000;
    else
      next_r.pre_cnt = r.pre_cnt + 24'h000001;

    if (pwr_fall)
    begin
      // snapshot what an always-on store would keep, then drop the output
      next_r.sv_mode    = r.mode;
      next_r.sv_sw      = r.sw;
      next_r.sv_elapsed = r.elapsed;
      next_r.sv_target  = r.target;
      next_r.sw         = 1'b0;
    end
    else if (pwr_rise)
    begin
      if (r.ctrl[`RDSW_CTRL_RETAIN])
      begin
        next_r.mode    = r.sv_mode;
        next_r.sw      = r.sv_sw;
        next_r.elapsed = r.sv_elapsed;
        next_r.target  = r.sv_target;
      end
      else
      begin
        next_r.mode    = RDSW_IDLE;
        next_r.sw      = 1'b0;
        next_r.elapsed = 16'h0000;
        next_r.target  = 16'h0000;
      end
    end
    else if (gate_rise)
    begin
      next_r.mode    = RDSW_ON_WAIT;
      next_r.target  = scale(rand_value, lim_on);
      next_r.elapsed = 16'h0000;
    end
    else if (gate_fall)
    begin
      next_r.mode    = RDSW_OFF_WAIT;
      next_r.target  = scale(rand_value, lim_off);
      next_r.elapsed = 16'h0000;
    end
    else if (r.pwr_s2)
    begin
      case (r.mode)
        RDSW_ON_WAIT:
        begin
          if (r.elapsed >= r.target)
          begin
            next_r.sw   = 1'b1;
            next_r.mode = RDSW_IDLE;
          end
          else if (tick)
            next_r.elapsed = r.elapsed + 16'h0001;
        end
        RDSW_OFF_WAIT:
        begin
          if (r.elapsed >= r.target)
          begin
            next_r.sw   = 1'b0;
            next_r.mode = RDSW_IDLE;
          end
          else if (tick)
            next_r.elapsed = r.elapsed + 16'h0001;
        end
        RDSW_IDLE:
          next_r.mode = RDSW_IDLE;
        default:
          next_r.mode = RDSW_IDLE;
      endcase
    end

    // write channels are taken independently, in either order or in the same cycle, answered after both
    next_r.awready = ~r.aw_got & ~r.bvalid;
    next_r.wready  = ~r.w_got & ~r.bvalid;
    if (r.awready && i_awvalid)
    begin
      next_r.aw_got  = 1'b1;
      next_r.aw_addr = i_awaddr;
      next_r.awready = 1'b0;
    end
    if (r.wready && i_wvalid)
    begin
      next_r.w_got  = 1'b1;
      next_r.wdata  = i_wdata;
      next_r.wstrb  = i_wstrb;
      next_r.wready = 1'b0;
    end
    if (r.aw_got && r.w_got && !r.bvalid)
    begin
      next_r.aw_got = 1'b0;
      next_r.w_got  = 1'b0;
      next_r.bvalid = 1'b1;
      next_r.bresp  = addr_ok(r.aw_addr) ? `RDSW_RESP_OKAY : `RDSW_RESP_SLVERR;
      case (r.aw_addr)
        `RDSW_ADDR_CTRL:
        begin
          wmerged     = merge({29'h00000000, r.ctrl}, r.wdata, r.wstrb);
          next_r.ctrl = wmerged[2:0];
        end
        `RDSW_ADDR_MAX_ON:
        begin
          wmerged       = merge({16'h0000, r.max_on}, r.wdata, r.wstrb);
          next_r.max_on = wmerged[15:0];
        end
        `RDSW_ADDR_MAX_OFF:
        begin
          wmerged        = merge({16'h0000, r.max_off}, r.wdata, r.wstrb);
          next_r.max_off = wmerged[15:0];
        end
        `RDSW_ADDR_TIMEBASE:
        begin
          wmerged         = merge({8'h00, r.prescale}, r.wdata, r.wstrb);
          next_r.prescale = wmerged[23:0];
        end
        default:
          wmerged = 32'h00000000;
      endcase
    end
    if (r.bvalid && i_bready)
    begin
      next_r.bvalid  = 1'b0;
      next_r.awready = 1'b1;
      next_r.wready  = 1'b1;
    end

    next_r.arready = ~r.rvalid & ~r.arready;
    if (r.arready && i_arvalid)
    begin
      next_r.arready = 1'b0;
      next_r.rvalid  = 1'b1;
      next_r.rresp   = addr_ok(i_araddr) ? `RDSW_RESP_OKAY : `RDSW_RESP_SLVERR;
      case (i_araddr)
        `RDSW_ADDR_CTRL:     next_r.rdata = {29'h00000000, r.ctrl};
        `RDSW_ADDR_MAX_ON:   next_r.rdata = {16'h0000, r.max_on};
        `RDSW_ADDR_MAX_OFF:  next_r.rdata = {16'h0000, r.max_off};
        `RDSW_ADDR_TIMEBASE: next_r.rdata = {8'h00, r.prescale};
        `RDSW_ADDR_STATUS:   next_r.rdata = {27'h0000000, r.pwr_s2, r.mode, r.gate_s2, r.sw};
        `RDSW_ADDR_ELAPSED:  next_r.rdata = {16'h0000, r.elapsed};
        `RDSW_ADDR_TARGET:   next_r.rdata = {16'h0000, r.target};
        default:             next_r.rdata = 32'h00000000;
      endcase
    end
    else if (r.arready)
      next_r.arready = 1'b1;
    if (r.rvalid && i_rready)
    begin
      next_r.rvalid  = 1'b0;
      next_r.arready = 1'b1;
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      r          <= '0;
      r.mode     <= RDSW_IDLE;
      r.sv_mode  <= RDSW_IDLE;
      r.max_on   <= `RDSW_MAX_ON_RST;
      r.max_off  <= `RDSW_MAX_OFF_RST;
      r.prescale <= 24'(TICK_CYCLES);
    end
    else
      r <= next_r;
  end

  assign o_switch       = r.sw;
  assign o_elapsed_time = r.elapsed;
  assign o_awready      = r.awready;
  assign o_wready       = r.wready;
  assign o_bresp        = r.bresp;
  assign o_bvalid       = r.bvalid;
  assign o_arready      = r.arready;
  assign o_rdata        = r.rdata;
  assign o_rresp        = r.rresp;
  assign o_rvalid       = r.rvalid;

endmodule : rdsw_top
`default_nettype wire

//--- test/rdsw_chk.sv
`timescale 1ns/10ps
`default_nettype none
module rdsw_chk (
  input wire logic        i_sys_clk,
  input wire logic        i_reset_n,
  input wire logic        i_gate,
  input wire logic        i_power_ok,
  input wire logic        o_switch,
  input wire logic [15:0] o_elapsed_time,
  input wire logic        i_awvalid,
  input wire logic        o_awready,
  input wire logic        i_wvalid,
  input wire logic        o_wready,
  input wire logic        o_bvalid,
  input wire logic [1:0]  o_bresp,
  input wire logic        i_bready,
  input wire logic        i_arvalid,
  input wire logic        o_arready,
  input wire logic        o_rvalid,
  input wire logic [31:0] o_rdata,
  input wire logic        i_rready
);
  default clocking cb @(posedge i_sys_clk);
  endclocking
  default disable iff (!i_reset_n);
  sequence s_wr_taken;
    i_awvalid && o_awready && i_wvalid && o_wready;
  endsequence
  // the pin reaches the state machine through three flops
  sequence s_gate_was(logic v);
    $past(i_gate, 3) == v || $past(i_gate, 4) == v || $past(i_gate, 5) == v;
  endsequence
  sequence s_pwr_back;
    !$past(i_power_ok, 4) || !$past(i_power_ok, 5);
  endsequence
  sequence s_pwr_gone;
    !$past(i_power_ok, 2) || !$past(i_power_ok, 3) || !$past(i_power_ok, 4);
  endsequence
  a_set_cause: assert property ($rose(o_switch) |-> s_gate_was(1'h1) or s_pwr_back)
    else $error("switch rose without gate high");
  a_clear_cause: assert property ($fell(o_switch) |-> s_gate_was(1'h0) or s_pwr_gone)
    else $error("switch fell without gate low");
  a_elapsed_step: assert property (!$stable(o_elapsed_time) |->
    o_elapsed_time == 16'h0000 || o_elapsed_time == $past(o_elapsed_time) + 16'h0001)
    else $error("elapsed time jumped");
  a_off_dark: assert property (!i_power_ok [*4] |-> !o_switch)
    else $error("switch on while unpowered");
  a_write_answer: assert property (s_wr_taken |-> ##[1:2] o_bvalid)
    else $error("write response missing");
  a_bresp_hold: assert property (o_bvalid && !i_bready |=> o_bvalid && $stable(o_bresp))
    else $error("write response dropped");
  a_aw_refused: assert property (o_bvalid |-> !o_awready && !o_wready)
    else $error("write taken during response");
  a_read_answer: assert property (i_arvalid && o_arready |=> ##[0:1] o_rvalid)
    else $error("read data missing");
  a_rdata_hold: assert property (o_rvalid && !i_rready |=> o_rvalid && $stable(o_rdata))
    else $error("read data dropped");
  a_ar_refused: assert property (o_rvalid |-> !o_arready)
    else $error("read taken during data");
endmodule : rdsw_chk
bind rdsw_top rdsw_chk rdsw_chk_i (
  .i_sys_clk      (i_sys_clk),
  .i_reset_n      (i_reset_n),
  .i_gate         (i_gate),
  .i_power_ok     (i_power_ok),
  .o_switch       (o_switch),
  .o_elapsed_time (o_elapsed_time),
  .i_awvalid      (i_awvalid),
  .o_awready      (o_awready),
  .i_wvalid       (i_wvalid),
  .o_wready       (o_wready),
  .o_bvalid       (o_bvalid),
  .o_bresp        (o_bresp),
  .i_bready       (i_bready),
  .i_arvalid      (i_arvalid),
  .o_arready      (o_arready),
  .o_rvalid       (o_rvalid),
  .o_rdata        (o_rdata),
  .i_rready       (i_rready)
);
`default_nettype wire

//--- test/rdsw_feed.sv
`timescale 1ns/10ps
`default_nettype none
module rdsw_feed (
  input  wire logic        i_sys_clk,
  input  wire logic        i_gate_cmd,
  input  wire logic        i_pwr_cmd,
  input  wire logic [15:0] i_on_cmd,
  input  wire logic [15:0] i_off_cmd,
  output var  logic        o_gate = 1'h0,
  output var  logic        o_power_ok = 1'h1,
  output var  logic [15:0] o_ext_on = 16'h0000,
  output var  logic [15:0] o_ext_off = 16'h0000
);
  // upstream levels and the neighbour block's live values leave a register
  always @(posedge i_sys_clk)
  begin
    o_gate <= i_gate_cmd;
    o_power_ok <= i_pwr_cmd;
    o_ext_on <= i_on_cmd;
    o_ext_off <= i_off_cmd;
  end
endmodule : rdsw_feed
`default_nettype wire

//--- test/random_delay_switch_bench.sv
`timescale 1ns/10ps
`default_nettype none
module random_delay_switch_bench;
  logic        i_sys_clk = 1'h0;
  logic        i_reset_n = 1'h0;
  logic        i_gate, i_power_ok, o_switch, g = 1'h0, p = 1'h1;
  logic [15:0] i_ext_max_on, i_ext_max_off, o_elapsed_time;
  logic [15:0] eon = 16'h0000, eoff = 16'h0000;
  logic [7:0]  i_awaddr = 8'h00, i_araddr = 8'h00;
  logic [31:0] i_wdata = 32'h0, o_rdata;
  logic [3:0]  i_wstrb = 4'hF;
  logic [1:0]  o_bresp, o_rresp;
  logic        i_awvalid = 1'h0, i_wvalid = 1'h0, i_bready = 1'h0, i_arvalid = 1'h0, i_rready = 1'h0;
  logic        o_awready, o_wready, o_bvalid, o_arready, o_rvalid;
  int          bad_count = 0, samples_checked = 0;
  rdsw_feed rdsw_feed_i (
    .i_sys_clk (i_sys_clk),
    .i_gate_cmd(g),
    .i_pwr_cmd (p),
    .i_on_cmd  (eon),
    .i_off_cmd (eoff),
    .o_gate    (i_gate),
    .o_power_ok(i_power_ok),
    .o_ext_on  (i_ext_max_on),
    .o_ext_off (i_ext_max_off)
  );
  rdsw_top #(
    .TICK_CYCLES (4)
  ) rdsw_top_i (
    .i_sys_clk      (i_sys_clk),
    .i_reset_n      (i_reset_n),
    .i_gate         (i_gate),
    .i_power_ok     (i_power_ok),
    .i_ext_max_on   (i_ext_max_on),
    .i_ext_max_off  (i_ext_max_off),
    .o_switch       (o_switch),
    .o_elapsed_time (o_elapsed_time),
    .i_awaddr       (i_awaddr),
    .i_awvalid      (i_awvalid),
    .o_awready      (o_awready),
    .i_wdata        (i_wdata),
    .i_wstrb        (i_wstrb),
    .i_wvalid       (i_wvalid),
    .o_wready       (o_wready),
    .o_bresp        (o_bresp),
    .o_bvalid       (o_bvalid),
    .i_bready       (i_bready),
    .i_araddr       (i_araddr),
    .i_arvalid      (i_arvalid),
    .o_arready      (o_arready),
    .o_rdata        (o_rdata),
    .o_rresp        (o_rresp),
    .o_rvalid       (o_rvalid),
    .i_rready       (i_rready)
  );
  initial
    forever #5 i_sys_clk = ~i_sys_clk;
  task automatic conclude();
    $display("checks %0d errors %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : conclude
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
    samples_checked++;
    if (s !== e)
    begin
      bad_count++;
      $display("ERROR %s expected %h seen %h", n, e, s);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    @(posedge i_sys_clk);
    i_awaddr <= a;
    i_wdata <= d;
    i_awvalid <= 1'h1;
    i_wvalid <= 1'h1;
    i_bready <= 1'h1;
    do
    begin
      @(posedge i_sys_clk);
      if (o_awready)
        i_awvalid <= 1'h0;
      if (o_wready)
        i_wvalid <= 1'h0;
    end
    while (o_bvalid !== 1'h1);
    i_bready <= 1'h0;
    chk("bresp", er, o_bresp);
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [31:0] d, input logic [1:0] er);
    @(posedge i_sys_clk);
    i_araddr <= a;
    i_arvalid <= 1'h1;
    i_rready <= 1'h1;
    do
    begin
      @(posedge i_sys_clk);
      if (o_arready)
        i_arvalid <= 1'h0;
    end
    while (o_rvalid !== 1'h1);
    i_rready <= 1'h0;
    d = o_rdata;
    chk("rresp", er, o_rresp);
  endtask : rd
  task automatic rc(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] d;
    rd(a, d, 2'h0);
    chk("register", e, d);
  endtask : rc
  // bounded: a stuck switch must fail, not hang
  task automatic wait_sw(input logic v, input int n);
    while (n > 0 && o_switch !== v)
    begin
      @(posedge i_sys_clk);
      n--;
    end
    chk("switch", v, o_switch);
  endtask : wait_sw
  task automatic t_regs();
    logic [31:0] d;
    rc(8'h00, 32'h0);
    rc(8'h04, 32'h0000000A);
    rc(8'h08, 32'h0000000A);
    rc(8'h0C, 32'h00000004);
    rd(8'h1C, d, 2'h2);
    chk("unmapped", 32'h0, d);
    wr(8'h1C, 32'h1, 2'h2);
    wr(8'h10, 32'h1F, 2'h0);
    rc(8'h10, 32'h00000010);
    // only the low byte lane is written, the rest keeps its value
    i_wstrb <= 4'h1;
    wr(8'h0C, 32'hFFFFFF05, 2'h0);
    i_wstrb <= 4'hF;
    rc(8'h0C, 32'h00000005);
    wr(8'h0C, 32'h00000004, 2'h0);
    rc(8'h0C, 32'h00000004);
  endtask : t_regs
  task automatic t_dly(input logic on, input logic [15:0] m);
    logic [31:0] d;
    wr(on ? 8'h04 : 8'h08, {16'h0000, m}, 2'h0);
    g <= on;
    wait_sw(on, m * 4 + 16);
    rd(8'h18, d, 2'h0);
    chk("target", 1'h1, d[15:0] <= m);
  endtask : t_dly
  task automatic t_abort(input logic on);
    wr(on ? 8'h04 : 8'h08, 32'h0000FFFF, 2'h0);
    g <= on;
    repeat (40) @(posedge i_sys_clk);
    chk("running", 1'h1, o_elapsed_time >= 16'h0008);
    chk("held", !on, o_switch);
    g <= !on;
    repeat (6) @(posedge i_sys_clk);
    chk("restart", 1'h1, o_elapsed_time <= 16'h0001);
    chk("kept", !on, o_switch);
  endtask : t_abort
  task automatic t_keep();
    logic [15:0] e;
    wr(8'h00, 32'h1, 2'h0);
    e = o_elapsed_time;
    p <= 1'h0;
    repeat (8) @(posedge i_sys_clk);
    chk("dark", 1'h0, o_switch);
    p <= 1'h1;
    wait_sw(1'h1, 10);
    chk("retained", {16'h0000, e}, {16'h0000, o_elapsed_time});
    wr(8'h00, 32'h0, 2'h0);
    p <= 1'h0;
    repeat (8) @(posedge i_sys_clk);
    p <= 1'h1;
    repeat (10) @(posedge i_sys_clk);
    chk("default", 1'h0, o_switch);
    chk("cleared", 32'h0, {16'h0000, o_elapsed_time});
  endtask : t_keep
  task automatic t_ext();
    logic [31:0] d;
    eon <= 16'h0002;
    wr(8'h04, 32'h0000FFFF, 2'h0);
    wr(8'h08, 32'h0000FFFF, 2'h0);
    wr(8'h00, 32'h6, 2'h0);
    g <= 1'h0;
    repeat (8) @(posedge i_sys_clk);
    g <= 1'h1;
    wait_sw(1'h1, 24);
    rd(8'h18, d, 2'h0);
    chk("ext target", 1'h1, d[15:0] <= 16'h0002);
    g <= 1'h0;
    wait_sw(1'h0, 10);
  endtask : t_ext
  initial
  begin
    repeat (3000) @(posedge i_sys_clk);
    bad_count++;
    conclude();
  end
  initial
  begin
    repeat (8) @(posedge i_sys_clk);
    i_reset_n <= 1'h1;
    repeat (3) @(posedge i_sys_clk);
    t_regs();
    t_abort(1'h1);
    t_dly(1'h1, 16'h0000);
    t_dly(1'h0, 16'h0000);
    t_dly(1'h1, 16'h0003);
    t_abort(1'h0);
    t_dly(1'h0, 16'h0003);
    t_dly(1'h1, 16'h000A);
    t_keep();
    t_ext();
    conclude();
  end
endmodule : random_delay_switch_bench
`default_nettype wire
